// [bench/tb_top.sv]
// Self-checking bench for the voltage monitor control block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	localparam int MAXCYC = 40000;
	localparam int P      = 15;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic        pready, pslverr, e;
	logic        c0, c1, c2, osc, stop;
	logic        m0r, m1r, m1i;
	logic [15:0] mv;
	int          num_errors = 0;
	int          n_checks   = 0;
	int          cyc        = 0;

	vmrc_top #(.SETTLE_NS(300), .HAS_MON1_IRQ(1'b1)) vmrc_top_inst (
		.pclk(pclk), .presetn(presetn), .ce(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.cmp_threshold_zero(c0), .cmp_threshold_one(c1),
		.cmp_threshold_two(c2), .lowspeed_osc_clock(osc),
		.lowspeed_osc_stop(stop), .mon0_reset_req(m0r),
		.mon1_reset_req(m1r), .mon1_irq_req(m1i)
	);

	vmrc_analog_model vmrc_analog_model_inst (
		.supply_mv(mv), .osc_stop(stop), .cmp_zero(c0),
		.cmp_one(c1), .cmp_two(c2), .osc_clk(osc)
	);

	initial pclk = 1'b0;
	always #50 pclk = ~pclk;

	task summarize;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == MAXCYC) begin
			num_errors++;
			summarize();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task idle(input int n);
		repeat (n) @(posedge pclk);
	endtask : idle

	// Holds the request until pready is seen high at a rising edge.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && k < 20) begin
			@(posedge pclk);
			k++;
		end
		chk(32'(k < 20), 32'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(r, exp);
	endtask : rdc

	task set_mv(input logic [15:0] v);
		@(posedge pclk);
		mv <= v;
	endtask : set_mv

	// Waits for the first request pulse and compares which lines rose.
	task pulse(input int bound, input logic [2:0] exp);
		logic [2:0] v;
		int         k;
		v = 3'h0;
		for (k = 0; k < bound && v === 3'h0; k++) begin
			@(negedge pclk);
			v = {m0r, m1r, m1i};
		end
		chk({29'h0, v}, {29'h0, exp});
	endtask : pulse

	task t_reset;
		chk({29'h0, m0r, m1r, m1i}, 32'h0);
		chk({31'h0, stop}, 32'h1);
		rdc(8'h00, 32'h0);
		rdc(8'h10, 32'h1);
		rdc(8'h08, 32'h0);
		rdc(8'h04, 32'h8);
		apb(1'b0, 8'h14, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
		$display("test reset done");
	endtask : t_reset

	task t_level;
		wr(8'h00, 32'h7);
		rdc(8'h00, 32'h7);
		idle(10);
		rdc(8'h04, 32'h8);
		rdc(8'h0C, 32'h8);
		set_mv(16'd2700);
		idle(6);
		rdc(8'h04, 32'h0);
		rdc(8'h0C, 32'h8);
		set_mv(16'd2200);
		idle(6);
		rdc(8'h0C, 32'h0);
		rdc(8'h08, 32'h0);
		set_mv(16'd3500);
		idle(6);
		$display("test level done");
	endtask : t_level

	task t_mon0;
		wr(8'h08, 32'hC2);
		wr(8'h08, 32'hC3);
		rdc(8'h08, 32'hC3);
		set_mv(16'd1500);
		pulse(20, 3'b100);
		rdc(8'h08, 32'hC7);
		wr(8'h08, 32'hC7);
		rdc(8'h08, 32'hC7);
		wr(8'h08, 32'hC3);
		rdc(8'h08, 32'hC3);
		set_mv(16'd3500);
		pulse(20, 3'b000);
		wr(8'h08, 32'h0);
		rdc(8'h08, 32'hC2);
		$display("test monitor0 done");
	endtask : t_mon0

	task t_mon1;
		wr(8'h0C, 32'h82);
		wr(8'h0C, 32'h83);
		rdc(8'h0C, 32'h8B);
		set_mv(16'd2200);
		pulse(20, 3'b001);
		set_mv(16'd3500);
		wr(8'h0C, 32'h0);
		wr(8'h0C, 32'hC2);
		wr(8'h0C, 32'hC3);
		set_mv(16'd2200);
		pulse(20, 3'b010);
		set_mv(16'd3500);
		wr(8'h0C, 32'h0);
		$display("test monitor1 done");
	endtask : t_mon1

	// Enabling too early must be refused; the wait scales with the divider.
	task t_filter;
		int          s;
		int          n;
		logic [31:0] cfg;
		wr(8'h10, 32'h0);
		rdc(8'h10, 32'h0);
		chk({31'h0, stop}, 32'h0);
		for (s = 0; s < 4; s++) begin
			n = 1 << s;
			cfg = 32'(s << 4);
			wr(8'h0C, cfg);
			idle(12 * n * 14);
			wr(8'h0C, cfg | 32'h1);
			rdc(8'h0C, cfg | 32'h8);
			idle((16 * n + 3) * P);
			wr(8'h0C, cfg | 32'h1);
			rdc(8'h0C, cfg | 32'h9);
			set_mv(16'd2200);
			pulse((12 * n + 4) * P, 3'b001);
			set_mv(16'd3500);
			pulse((12 * n + 4) * P, 3'b001);
			wr(8'h0C, 32'h0);
		end
		$display("test filter done");
	endtask : t_filter

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		mv = 16'd3500;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_level();
		t_mon0();
		t_mon1();
		t_filter();
		summarize();
	end
endmodule : tb_top
`default_nettype wire

// [bench/vmrc_analog_model.sv]
// Behavioural comparators and slow oscillator facing the monitor block.
`timescale 1ns/100ps
`default_nettype none
module vmrc_analog_model #(
	parameter int TH0_MV   = 2000,
	parameter int TH1_MV   = 2500,
	parameter int TH2_MV   = 3000,
	parameter int OSC_HALF = 730
) (
	input  wire logic [15:0] supply_mv,
	input  wire logic        osc_stop,
	output logic             cmp_zero,
	output logic             cmp_one,
	output logic             cmp_two,
	output logic             osc_clk
);
	// A comparator reads 1 while the supply is at or above its threshold.
	assign cmp_zero = (supply_mv >= 16'(TH0_MV));
	assign cmp_one  = (supply_mv >= 16'(TH1_MV));
	assign cmp_two  = (supply_mv >= 16'(TH2_MV));
	// The period is not a multiple of the bus clock, so ticks drift in phase.
	// A stopped oscillator stands low and gives the filter no ticks.
	initial begin
		osc_clk = 1'b0;
		forever begin
			#(OSC_HALF);
			osc_clk = ~osc_clk & ~osc_stop;
		end
	end
endmodule : vmrc_analog_model
`default_nettype wire

// [common/vmrc_filt_if.sv]
// Signals between the monitor control and one digital filter.
`timescale 1ns/100ps
`default_nettype none
interface vmrc_filt_if;
	import vmrc_pkg::*;
	logic      ce;
	logic      osc_tick;
	vmrc_sel_t sel;
	logic      cmp;
	logic      restart;
	logic      level;
	logic      warm_done;
	modport filt (input ce, osc_tick, sel, cmp, restart,
		output level, warm_done);
	modport ctl (output ce, osc_tick, sel, cmp, restart,
		input level, warm_done);
endinterface : vmrc_filt_if
`default_nettype wire

// [common/vmrc_params.svh]
// Offsets, field positions, reset values and timing figures of the monitor block.
`ifndef VMRC_PARAMS_SVH
`define VMRC_PARAMS_SVH
`define VMRC_OFF_DETEN   8'h00
`define VMRC_OFF_DETLVL  8'h04
`define VMRC_OFF_MON0    8'h08
`define VMRC_OFF_MON1    8'h0C
`define VMRC_OFF_CLKMODE 8'h10
`define VMRC_B_EN        0
`define VMRC_B_FDIS      1
`define VMRC_B_FLAG      2
`define VMRC_B_LVL       3
`define VMRC_B_SEL       4
`define VMRC_B_MODE      6
`define VMRC_B_TIM       7
`define VMRC_B_DET2LVL   3
`define VMRC_B_OSCSTOP   0
`define VMRC_RST_DETEN   3'h0
`define VMRC_RST_OSCSTOP 1'h1
`define VMRC_SETTLE_NS   100000
`define VMRC_CLK_NS      100
`define VMRC_SAMPLE_DIV  6'h04
`define VMRC_WARM_SAMPLES 4
`endif

// [common/vmrc_pkg.sv]
// Types shared by the voltage monitor control block.
package vmrc_pkg;
	typedef logic [1:0] vmrc_sel_t;
	typedef struct packed {
		logic      en;
		logic      fdis;
		logic      flag;
		vmrc_sel_t sel;
		logic      mode;
		logic      tim;
	} vmrc_mon_s;
endpackage : vmrc_pkg

// [design/vmrc_filter.sv]
// Digital noise filter for one comparator, clocked by oscillator ticks.
`timescale 1ns/100ps
`default_nettype none
`include "vmrc_params.svh"
module vmrc_filter
	import vmrc_pkg::*;
#(
	parameter int WARM_SAMPLES = `VMRC_WARM_SAMPLES
) (
	input wire logic    pclk,
	input wire logic    presetn,
	vmrc_filt_if.filt   fi
);
	if (WARM_SAMPLES < 1 || WARM_SAMPLES > 7) begin : g_chk
		$error("WARM_SAMPLES out of range");
	end

	logic [5:0] div_ff;
	logic [5:0] period;
	logic       samp;
	logic [1:0] smp_ff;
	logic       level_ff;
	logic [2:0] warm_ff;

	assign period = `VMRC_SAMPLE_DIV << fi.sel;
	assign samp = fi.osc_tick && (div_ff == period - 6'h01);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff <= 6'h00;
		end else if (fi.ce) begin
			if (fi.restart) begin
				div_ff <= 6'h00;
			end else if (fi.osc_tick) begin
				div_ff <= samp ? 6'h00 : div_ff + 6'h01;
			end
		end
	end

	// A level moves only after two samples agree, so a single glitch is lost.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			smp_ff   <= 2'h3;
			level_ff <= 1'b1;
		end else if (fi.ce && samp) begin
			smp_ff <= {smp_ff[0], fi.cmp};
			if (smp_ff[0] == fi.cmp) begin
				level_ff <= fi.cmp;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			warm_ff <= 3'h0;
		end else if (fi.ce) begin
			if (fi.restart) begin
				warm_ff <= 3'h0;
			end else if (samp && warm_ff != 3'(WARM_SAMPLES)) begin
				warm_ff <= warm_ff + 3'h1;
			end
		end
	end

	assign fi.level     = level_ff;
	assign fi.warm_done = (warm_ff == 3'(WARM_SAMPLES));

	property p_filt_warm;
		@(posedge pclk) disable iff (!presetn)
		$rose(fi.warm_done) |-> $past(samp) && $past(fi.ce);
	endproperty
	a_filt_warm: assert property (p_filt_warm)
		else $error("filter warm-up ended without a sample");

	property p_filt_step;
		@(posedge pclk) disable iff (!presetn)
		$changed(level_ff) |-> $past(samp) && $past(fi.cmp) == level_ff;
	endproperty
	a_filt_step: assert property (p_filt_step)
		else $error("filtered level moved off a sample point");
endmodule : vmrc_filter
`default_nettype wire

// [design/vmrc_top.sv]
// Voltage monitor control: detector enables, filters, flags and requests.
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "vmrc_params.svh"
// Notes on behaviour
// - After detector 1 settles, its live level reads in monitor 1 control.
// - After detector 2 settles, its live level reads in the level register.
// - Threshold zero has no readable level bit; it only feeds monitor 0.
// - Filter-disable 0 filters, 1 bypasses; two-bit field picks sample clock.
// - Monitor 0 mode 1 selects reset; monitor 0 has no interrupt.
// - With filter on, enable waits four sample clocks after setup.
// - Writing monitor 0 enable arms its reset generation.
// - While disabled, select, filter-disable and mode update in one write.
// - Monitor 1 mode 0 gives interrupt, 1 gives reset.
// - Monitor 1 filter samples at its own two-bit selection.
// - Writing monitor 1 enable arms interrupt or reset by mode.
// - Reduced variant: monitor 1 mode is fixed to reset, no interrupt.
// - Sample period is four slow-oscillator periods multiplied by 1, 2, 4, 8.
// - Crossing flag clears on a written 0 and ignores a written 1.
module vmrc_top
	import vmrc_pkg::*;
#(
	parameter int SETTLE_NS    = `VMRC_SETTLE_NS,
	parameter bit HAS_MON1_IRQ = 1'b1
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cmp_threshold_zero,
	input  wire logic        cmp_threshold_one,
	input  wire logic        cmp_threshold_two,
	input  wire logic        lowspeed_osc_clock,
	output logic             lowspeed_osc_stop,
	output logic             mon0_reset_req,
	output logic             mon1_reset_req,
	output logic             mon1_irq_req
);
	localparam int SETTLE_CYC =
		(SETTLE_NS + `VMRC_CLK_NS - 1) / `VMRC_CLK_NS;

	if (SETTLE_CYC < 1 || SETTLE_CYC > 4095) begin : g_chk
		$error("SETTLE_NS gives an unusable cycle count");
	end

	function automatic logic [7:0] pack_ctrl(vmrc_mon_s m, logic lvl);
		logic [7:0] r;
		r = 8'h00;
		r[`VMRC_B_EN]         = m.en;
		r[`VMRC_B_FDIS]       = m.fdis;
		r[`VMRC_B_FLAG]       = m.flag;
		r[`VMRC_B_LVL]        = lvl;
		r[`VMRC_B_SEL +: 2]   = m.sel;
		r[`VMRC_B_MODE]       = m.mode;
		r[`VMRC_B_TIM]        = m.tim;
		return r;
	endfunction : pack_ctrl

	logic [2:0]  det_en_ff;
	logic [2:0]  settled;
	logic [2:0]  cmp_s1_ff;
	logic [2:0]  cmp_s2_ff;
	logic [2:0]  osc_sync_ff;
	logic        osc_stop_ff;
	logic        osc_tick;
	vmrc_mon_s   mon_ff [2];
	logic [1:0]  lvl;
	logic [1:0]  lvl_q_ff;
	logic [1:0]  hit;
	logic [1:0]  wr_ctrl;
	logic [1:0]  warm_done;
	logic [1:0]  rst_req_ff;
	logic        irq_ff;
	logic        setup;
	logic        wr;
	logic        err_ff;
	logic        det1_level_status;
	logic        det2_level_status;

	assign setup   = psel && !penable && ce;
	assign wr      = psel && penable && pwrite && ce;
	assign pready  = psel && penable && ce;
	assign pslverr = pready && err_ff;

	// Reads are latched in the setup cycle so prdata comes from a flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			err_ff <= 1'b0;
		end else if (setup) begin
			err_ff <= 1'b0;
			prdata <= 32'h0000_0000;
			if (paddr == `VMRC_OFF_DETEN) begin
				prdata[2:0] <= det_en_ff;
			end else if (paddr == `VMRC_OFF_DETLVL) begin
				prdata[`VMRC_B_DET2LVL] <= det2_level_status;
			end else if (paddr == `VMRC_OFF_MON0) begin
				prdata[7:0] <= pack_ctrl(mon_ff[0], 1'b0);
			end else if (paddr == `VMRC_OFF_MON1) begin
				prdata[7:0] <= pack_ctrl(mon_ff[1], det1_level_status);
			end else if (paddr == `VMRC_OFF_CLKMODE) begin
				prdata[`VMRC_B_OSCSTOP] <= osc_stop_ff;
			end else begin
				err_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			det_en_ff <= `VMRC_RST_DETEN;
		end else if (wr && paddr == `VMRC_OFF_DETEN) begin
			det_en_ff <= pwdata[2:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_stop_ff <= `VMRC_RST_OSCSTOP;
		end else if (wr && paddr == `VMRC_OFF_CLKMODE) begin
			osc_stop_ff <= pwdata[`VMRC_B_OSCSTOP];
		end
	end
	assign lowspeed_osc_stop = osc_stop_ff;

	// Comparators and the slow oscillator are asynchronous to pclk.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_s1_ff   <= 3'h7;
			cmp_s2_ff   <= 3'h7;
			osc_sync_ff <= 3'h0;
		end else if (ce) begin
			cmp_s1_ff   <= {cmp_threshold_two, cmp_threshold_one,
				cmp_threshold_zero};
			cmp_s2_ff   <= cmp_s1_ff;
			osc_sync_ff <= {osc_sync_ff[1:0], lowspeed_osc_clock};
		end
	end
	// A stopped oscillator gives no ticks; filters hold their level and warm-up restarts.
	assign osc_tick = osc_sync_ff[1] && !osc_sync_ff[2]
		&& !osc_stop_ff;

	for (genvar d = 0; d < 3; d++) begin : g_det
		logic [11:0] cnt_ff;
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cnt_ff <= 12'h000;
			end else if (ce) begin
				if (!det_en_ff[d]) begin
					cnt_ff <= 12'h000;
				end else if (cnt_ff != 12'(SETTLE_CYC)) begin
					cnt_ff <= cnt_ff + 12'h001;
				end
			end
		end
		assign settled[d] = (cnt_ff == 12'(SETTLE_CYC));
	end

	// An unsettled detector reads as supply above threshold.
	assign det1_level_status = settled[1] ? cmp_s2_ff[1] : 1'b1;
	assign det2_level_status = settled[2] ? cmp_s2_ff[2] : 1'b1;

	for (genvar m = 0; m < 2; m++) begin : g_mon
		vmrc_filt_if u_if ();
		logic cfg_we;
		logic en_req;
		logic fdis_new;
		logic rise;
		logic fall;

		assign wr_ctrl[m] = wr && (paddr == (m == 0 ? `VMRC_OFF_MON0
			: `VMRC_OFF_MON1));
		assign cfg_we = wr_ctrl[m] && !mon_ff[m].en;
		assign fdis_new = cfg_we ? pwdata[`VMRC_B_FDIS] : mon_ff[m].fdis;

		assign u_if.ce       = ce;
		assign u_if.osc_tick = osc_tick;
		assign u_if.sel      = mon_ff[m].sel;
		assign u_if.cmp      = cmp_s2_ff[m];
		assign u_if.restart  = cfg_we || mon_ff[m].fdis || osc_stop_ff;
		assign warm_done[m]  = u_if.warm_done;

		vmrc_filter u_filt (
			.pclk    (pclk),
			.presetn (presetn),
			.fi      (u_if.filt)
		);

		// Mode, filter and timing are frozen while the monitor is armed.
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				mon_ff[m].fdis <= 1'b0;
				mon_ff[m].sel  <= 2'h0;
				mon_ff[m].mode <= (m == 1) && !HAS_MON1_IRQ;
				mon_ff[m].tim  <= 1'b0;
			end else if (cfg_we) begin
				mon_ff[m].fdis <= pwdata[`VMRC_B_FDIS];
				mon_ff[m].sel  <= pwdata[`VMRC_B_SEL +: 2];
				mon_ff[m].mode <= pwdata[`VMRC_B_MODE]
					|| ((m == 1) && !HAS_MON1_IRQ);
				mon_ff[m].tim  <= pwdata[`VMRC_B_TIM];
			end
		end

		// Enable is refused until settled and, when filtering, warmed up.
		assign en_req = pwdata[`VMRC_B_EN] && settled[m]
			&& (fdis_new || warm_done[m]);
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				mon_ff[m].en <= 1'b0;
			end else if (ce && !det_en_ff[m]) begin
				mon_ff[m].en <= 1'b0;
			end else if (wr_ctrl[m]) begin
				mon_ff[m].en <= en_req;
			end
		end

		assign lvl[m] = mon_ff[m].fdis ? cmp_s2_ff[m] : u_if.level;
		assign rise = lvl[m] && !lvl_q_ff[m];
		assign fall = !lvl[m] && lvl_q_ff[m];
		// Bypassed monitors fire on one direction only; filtered on both.
		assign hit[m] = mon_ff[m].en && settled[m]
			&& (mon_ff[m].fdis ? (mon_ff[m].tim ? fall : rise)
			: (rise || fall));

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				lvl_q_ff[m] <= 1'b1;
			end else if (ce) begin
				lvl_q_ff[m] <= lvl[m];
			end
		end

		// A crossing in the same cycle as a clearing write wins.
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				mon_ff[m].flag <= 1'b0;
			end else if (ce && hit[m]) begin
				mon_ff[m].flag <= 1'b1;
			end else if (wr_ctrl[m] && !pwdata[`VMRC_B_FLAG]) begin
				mon_ff[m].flag <= 1'b0;
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				rst_req_ff[m] <= 1'b0;
			end else if (ce) begin
				rst_req_ff[m] <= hit[m] && mon_ff[m].mode;
			end
		end

		// Judged from the synchronised comparator, not the internal level.
		property p_bypass;
			@(posedge pclk) disable iff (!presetn)
			ce && mon_ff[m].fdis && mon_ff[m].en && $past(mon_ff[m].en)
				&& settled[m] && mon_ff[m].tim && $fell(cmp_s2_ff[m])
				|=> mon_ff[m].flag;
		endproperty
		a_bypass: assert property (p_bypass)
			else $error("bypassed monitor does not follow comparator");

		property p_cfg_hold;
			@(posedge pclk) disable iff (!presetn)
			$past(mon_ff[m].en) |-> $stable(mon_ff[m].mode)
				&& $stable(mon_ff[m].sel) && $stable(mon_ff[m].fdis);
		endproperty
		a_cfg_hold: assert property (p_cfg_hold)
			else $error("monitor setup changed while enabled");

		sequence s_en_rise;
			!mon_ff[m].en ##1 mon_ff[m].en;
		endsequence
		property p_warm;
			@(posedge pclk) disable iff (!presetn)
			s_en_rise |-> mon_ff[m].fdis || $past(warm_done[m]);
		endproperty
		a_warm: assert property (p_warm)
			else $error("monitor enabled before filter warm-up");

		property p_arm;
			@(posedge pclk) disable iff (!presetn)
			s_en_rise |-> $past(wr_ctrl[m]) && $past(settled[m]);
		endproperty
		a_arm: assert property (p_arm)
			else $error("monitor armed without an enabling write");

		sequence s_reset_hit;
			ce && hit[m] && mon_ff[m].mode;
		endsequence
		property p_reset;
			@(posedge pclk) disable iff (!presetn)
			s_reset_hit |=> rst_req_ff[m] && mon_ff[m].flag;
		endproperty
		a_reset: assert property (p_reset)
			else $error("armed crossing gave no reset request");

		property p_flag_set;
			@(posedge pclk) disable iff (!presetn)
			$rose(mon_ff[m].flag) |-> $past(hit[m]);
		endproperty
		a_flag_set: assert property (p_flag_set)
			else $error("crossing flag set without a crossing");
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ff <= 1'b0;
		end else if (ce) begin
			irq_ff <= HAS_MON1_IRQ && hit[1]
				&& !mon_ff[1].mode;
		end
	end

	assign mon0_reset_req = rst_req_ff[0];
	assign mon1_reset_req = rst_req_ff[1];
	assign mon1_irq_req   = irq_ff;

	property p_irq;
		@(posedge pclk) disable iff (!presetn)
		ce && hit[1] && !mon_ff[1].mode |=> mon1_irq_req == HAS_MON1_IRQ
			&& !mon1_reset_req;
	endproperty
	a_irq: assert property (p_irq)
		else $error("monitor 1 interrupt mode misrouted");

	property p_reduced;
		@(posedge pclk) disable iff (!presetn)
		!HAS_MON1_IRQ |-> !mon1_irq_req && mon_ff[1].mode;
	endproperty
	a_reduced: assert property (p_reduced)
		else $error("reduced variant raised an interrupt");

	property p_no_irq0;
		@(posedge pclk) disable iff (!presetn)
		ce && hit[0] && !mon_ff[0].mode |=> !mon0_reset_req;
	endproperty
	a_no_irq0: assert property (p_no_irq0)
		else $error("monitor 0 reset outside reset mode");

	property p_lvl1;
		@(posedge pclk) disable iff (!presetn)
		settled[1] |-> det1_level_status == cmp_s2_ff[1];
	endproperty
	a_lvl1: assert property (p_lvl1)
		else $error("detector 1 level not live after settling");

	property p_lvl2;
		@(posedge pclk) disable iff (!presetn)
		settled[2] |-> det2_level_status == cmp_s2_ff[2];
	endproperty
	a_lvl2: assert property (p_lvl2)
		else $error("detector 2 level not live after settling");
endmodule : vmrc_top
`default_nettype wire
